// file: design/cscc_pkg.sv
package cscc_pkg;

  // Clock and documented times, each in nanoseconds.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SR_CYCLE_NS    = 4000;
  localparam int READ_NS        = 830;
  localparam int WRITE_START_NS = 2830;
  localparam int WRITE_LEN_NS   = 1800;

  // Cycle counts: durations round down, the start delay rounds up.
  localparam int SR_CYCLE_CYC    = SR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int READ_CYC        = READ_NS / CLK_PERIOD_NS;
  localparam int WRITE_START_CYC =
    (WRITE_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_LEN_CYC   = WRITE_LEN_NS / CLK_PERIOD_NS;

  localparam int PULSES_PER_SR  = 24;
  localparam int PULSES_PER_EXC = 8;

  localparam int WORD_W    = 8;
  localparam int ADDR_W    = 12;
  localparam int WORDS_2K  = 2048;
  localparam int WORDS_4K  = 4096;
  localparam int PLANE_DIM = 64;

  // Octal groups of the storage address register.
  localparam int VDRV_B2 = 11;
  localparam int VDRV_B1 = 9;
  localparam int VDRV_B0 = 8;
  localparam int HDRV_B2 = 10;
  localparam int HDRV_B1 = 7;
  localparam int HDRV_B0 = 6;
  localparam int VDIV_LSB = 3;
  localparam int HDIV_LSB = 0;
  localparam int BANK_BIT = 11;

  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

  typedef enum logic [4:0] {
    CSCC_CYC_D  = 5'h01,
    CSCC_CYC_A  = 5'h02,
    CSCC_CYC_B  = 5'h04,
    CSCC_CYC_C  = 5'h08,
    CSCC_CYC_C2 = 5'h10
  } cscc_cycle_type;

  typedef enum logic [2:0] {
    CSCC_SEQ_SINGLE   = 3'h0,
    CSCC_SEQ_NO_ADDR  = 3'h1,
    CSCC_SEQ_DIRECT   = 3'h2,
    CSCC_SEQ_INDIRECT = 3'h3,
    CSCC_SEQ_REPLACE  = 3'h4,
    CSCC_SEQ_EXT_FN   = 3'h5
  } cscc_seq_kind_type;

endpackage : cscc_pkg

// file: design/cscc_phase_timer.sv
`timescale 1ns/1ps
module cscc_phase_timer
  import cscc_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  input  wire logic       start_i,
  output logic            ready_o,
  output logic            active_o,
  output logic            read_o,
  output logic            write_o,
  output logic            inhibit_o,
  output logic            divert_o,
  output logic            cycle_end_o,
  output logic [4:0]      pulse_o,
  output logic [1:0]      excursion_o
);

  logic [8:0]  cnt;
  logic [7:0]  wcnt;
  logic [13:0] scaled;
  logic [4:0]  pulse_idx;
  logic [1:0]  exc_bin;
  wire         go        = start_i && ready_o;
  wire         cnt_last  = active_o && (cnt == 9'(SR_CYCLE_CYC - 1));
  wire         read_end  = active_o && (cnt == 9'(READ_CYC - 1));
  wire         write_set = active_o && (cnt == 9'(WRITE_START_CYC - 1));
  wire         write_end = write_o && (wcnt == 8'(WRITE_LEN_CYC - 1));

  // A new cycle waits for the boundary and for the last write to finish.
  assign ready_o     = !active_o && !write_o;
  assign scaled      = 14'(cnt) * 14'(PULSES_PER_SR);
  assign pulse_idx   = 5'(scaled / 14'(SR_CYCLE_CYC));
  assign exc_bin     = 2'(pulse_idx / 5'(PULSES_PER_EXC));
  assign pulse_o     = pulse_idx;
  assign excursion_o = {exc_bin[1], exc_bin[1] ^ exc_bin[0]};

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cnt         <= '0;
      wcnt        <= '0;
      active_o    <= 1'b0;
      read_o      <= 1'b0;
      write_o     <= 1'b0;
      inhibit_o   <= 1'b0;
      divert_o    <= 1'b0;
      cycle_end_o <= 1'b0;
    end else if (ce_i) begin
      cycle_end_o <= cnt_last;
      if (go) begin
        active_o <= 1'b1;
        cnt      <= '0;
      end else if (cnt_last) begin
        active_o <= 1'b0;
      end else if (active_o) begin
        cnt <= cnt + 9'd1;
      end
      // Each phase is one flip-flop set and cleared at a fixed count.
      if (go) read_o <= 1'b1;
      else if (read_end) read_o <= 1'b0;
      if (write_set) begin
        write_o   <= 1'b1;
        inhibit_o <= 1'b1;
        wcnt      <= '0;
      end else if (write_end) begin
        write_o   <= 1'b0;
        inhibit_o <= 1'b0;
      end else if (write_o) begin
        wcnt <= wcnt + 8'd1;
      end
      if (go) divert_o <= 1'b1;
      else if (write_end) divert_o <= 1'b0;
    end
  end

endmodule : cscc_phase_timer

// file: design/cscc_seq_ctrl.sv
`timescale 1ns/1ps
module cscc_seq_ctrl
  import cscc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire logic              instr_start_i,
  input  wire cscc_seq_kind_type kind_i,
  input  wire logic              grant_i,
  input  wire logic              cycle_end_i,
  output logic                   req_o,
  output logic                   busy_o,
  output logic                   instr_done_o,
  output cscc_cycle_type         cycle_type_o,
  output logic [2:0]             cycles_o
);

  typedef enum logic [2:0] {
    CSCC_S_IDLE = 3'h1,
    CSCC_S_REQ  = 3'h2,
    CSCC_S_RUN  = 3'h4
  } cscc_seq_state_type;

  cscc_seq_state_type state;
  cscc_seq_kind_type  kind;
  logic [1:0]         idx;

  // Number of references made by each sequence.
  function automatic logic [2:0] seq_len(input cscc_seq_kind_type k);
    case (k)
      CSCC_SEQ_SINGLE:   seq_len = 3'd1;
      CSCC_SEQ_NO_ADDR:  seq_len = 3'd2;
      CSCC_SEQ_DIRECT:   seq_len = 3'd3;
      CSCC_SEQ_EXT_FN:   seq_len = 3'd3;
      default:           seq_len = 3'd4;
    endcase
  endfunction : seq_len

  // Cycle type at a given step of a sequence.
  function automatic cscc_cycle_type seq_step(input cscc_seq_kind_type k,
                                              input logic [1:0] i);
    seq_step = CSCC_CYC_D;
    case (k)
      CSCC_SEQ_NO_ADDR:
        if (i == 2'd1) seq_step = CSCC_CYC_C;
      CSCC_SEQ_DIRECT:
        if (i == 2'd1) seq_step = CSCC_CYC_B;
        else if (i == 2'd2) seq_step = CSCC_CYC_C;
      CSCC_SEQ_INDIRECT:
        if (i == 2'd1) seq_step = CSCC_CYC_A;
        else if (i == 2'd2) seq_step = CSCC_CYC_B;
        else if (i == 2'd3) seq_step = CSCC_CYC_C;
      CSCC_SEQ_REPLACE:
        if (i == 2'd1) seq_step = CSCC_CYC_B;
        else if (i == 2'd2) seq_step = CSCC_CYC_C;
        else if (i == 2'd3) seq_step = CSCC_CYC_C2;
      CSCC_SEQ_EXT_FN:
        if (i == 2'd1) seq_step = CSCC_CYC_C;
        else if (i == 2'd2) seq_step = CSCC_CYC_C2;
      default: seq_step = CSCC_CYC_D;
    endcase
  endfunction : seq_step

  wire last_step = ({1'b0, idx} == seq_len(kind) - 3'd1);

  assign req_o        = (state == CSCC_S_REQ);
  assign busy_o       = (state != CSCC_S_IDLE);
  assign cycle_type_o = seq_step(kind, idx);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      state        <= CSCC_S_IDLE;
      kind         <= CSCC_SEQ_SINGLE;
      idx          <= '0;
      cycles_o     <= '0;
      instr_done_o <= 1'b0;
    end else if (ce_i) begin
      instr_done_o <= 1'b0;
      case (state)
        CSCC_S_IDLE: begin
          if (instr_start_i) begin
            kind     <= kind_i;
            idx      <= '0;
            cycles_o <= '0;
            state    <= CSCC_S_REQ;
          end
        end
        CSCC_S_REQ: begin
          if (grant_i) state <= CSCC_S_RUN;
        end
        CSCC_S_RUN: begin
          if (cycle_end_i) begin
            cycles_o <= cycles_o + 3'd1;
            if (last_step) begin
              instr_done_o <= 1'b1;
              state        <= CSCC_S_IDLE;
            end else begin
              idx   <= idx + 2'd1;
              state <= CSCC_S_REQ;
            end
          end
        end
        default: state <= CSCC_S_IDLE;
      endcase
    end
  end

endmodule : cscc_seq_ctrl

// file: design/cscc_storage_ctrl.sv
`timescale 1ns/1ps
module cscc_storage_ctrl
  import cscc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire logic              size_4k_i,
  input  wire logic              run_i,
  input  wire logic              step_i,
  input  wire logic              instr_start_i,
  input  wire cscc_seq_kind_type seq_kind_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              use_buffer_i,
  input  wire logic              store_new_i,
  input  wire logic [WORD_W-1:0] write_data_i,
  input  wire logic [WORD_W-1:0] sense_i,
  output logic                   busy_o,
  output logic                   sr_req_o,
  output logic                   sr_active_o,
  output logic                   cycle_end_o,
  output logic                   instr_done_o,
  output cscc_cycle_type         cycle_type_o,
  output logic [2:0]             cycles_o,
  output logic [4:0]             pulse_o,
  output logic [1:0]             excursion_o,
  output logic                   read_phase_o,
  output logic                   write_phase_o,
  output logic                   inhibit_phase_o,
  output logic                   divert_phase_o,
  output logic                   read_drive_o,
  output logic                   write_drive_o,
  output logic [WORD_W-1:0]      inhibit_o,
  output logic [7:0]             vert_driver_o,
  output logic [7:0]             horz_driver_o,
  output logic [7:0]             vert_diverter_o,
  output logic [7:0]             horz_diverter_o,
  output logic [ADDR_W-1:0]      storage_addr_o,
  output logic [WORD_W-1:0]      storage_data_o,
  output logic [WORD_W-1:0]      buffer_data_o
);

  // One-of-eight selection from an octal digit.
  function automatic logic [7:0] octal_select(input logic [2:0] digit);
    case (digit)
      3'h0:    octal_select = 8'h01;
      3'h1:    octal_select = 8'h02;
      3'h2:    octal_select = 8'h04;
      3'h3:    octal_select = 8'h08;
      3'h4:    octal_select = 8'h10;
      3'h5:    octal_select = 8'h20;
      3'h6:    octal_select = 8'h40;
      3'h7:    octal_select = 8'h80;
      default: octal_select = 8'h00;
    endcase
  endfunction : octal_select

  // Synchronisers for the console switches and the sense amplifiers.
  logic              run_meta;
  logic              run_sync;
  logic              step_meta;
  logic              step_sync;
  logic              step_prev;
  logic [WORD_W-1:0] sense_meta;
  logic [WORD_W-1:0] sense_sync;
  logic              size_meta;
  logic              size_sync;

  // Cycle bookkeeping.
  logic              step_pending;
  logic              cycle_to_buffer;
  logic              cycle_new_data;

  // Wires between the submodules and the control below.
  logic              tmr_ready;
  logic              tmr_active;
  logic              tmr_read;
  logic              tmr_write;
  logic              tmr_inhibit;
  logic              tmr_divert;
  logic              tmr_end;
  logic              seq_req;
  logic              seq_busy;
  logic              seq_done;
  cscc_cycle_type    seq_type;
  logic [2:0]        seq_cycles;
  logic [4:0]        tmr_pulse;
  logic [1:0]        tmr_exc;

  // Selection and gating of the next cycle and of the data register.
  wire               step_edge;
  wire               may_run;
  wire               grant;
  wire [ADDR_W-1:0]  masked_addr;
  wire [WORD_W-1:0]  active_word;
  wire [WORD_W-1:0]  captured_word;
  wire [WORD_W-1:0]  start_word;
  wire               sense_open;
  wire [7:0]         vert_drv_sel;
  wire [7:0]         horz_drv_sel;
  wire [7:0]         vert_div_sel;
  wire [7:0]         horz_div_sel;

  assign step_edge   = step_sync && !step_prev;
  assign may_run     = run_sync || step_pending;
  // Requests are taken only once the timer reports a free boundary.
  assign grant       = seq_req && tmr_ready && may_run;

  // The 2048-word stack has no upper bank, so that address bit reads zero.
  assign masked_addr = size_sync ? addr_i
                                 : (addr_i & ~(ADDR_W'(1) << BANK_BIT));

  assign active_word = cycle_to_buffer ? buffer_data_o : storage_data_o;

  // Sense outputs are only let through while reading the old word.
  assign sense_open    = tmr_read && !cycle_new_data;
  assign captured_word = active_word | sense_sync;

  // Reading clears the cores, so an old word starts empty and is rebuilt.
  assign start_word  = store_new_i ? write_data_i : WORD_RESET;

  // Drive direction follows the phase flip-flops.
  assign read_drive_o  = tmr_read && tmr_divert;
  assign write_drive_o = tmr_write && tmr_divert;

  // One octal group per driver or diverter bank, shared by all planes.
  assign vert_drv_sel = octal_select({masked_addr[VDRV_B2],
                                      masked_addr[VDRV_B1],
                                      masked_addr[VDRV_B0]});
  assign horz_drv_sel = octal_select({masked_addr[HDRV_B2],
                                      masked_addr[HDRV_B1],
                                      masked_addr[HDRV_B0]});
  assign vert_div_sel = octal_select(masked_addr[VDIV_LSB +: 3]);
  assign horz_div_sel = octal_select(masked_addr[HDIV_LSB +: 3]);

  // A zero data bit energizes its plane's inhibit for the whole write.
  generate
    for (genvar b = 0; b < WORD_W; b++) begin : g_inhibit
      assign inhibit_o[b] = tmr_inhibit && !active_word[b];
    end
  endgenerate

  assign read_phase_o    = tmr_read;
  assign write_phase_o   = tmr_write;
  assign inhibit_phase_o = tmr_inhibit;
  assign divert_phase_o  = tmr_divert;
  assign sr_active_o     = tmr_active;
  assign cycle_end_o     = tmr_end;
  assign pulse_o         = tmr_pulse;
  assign excursion_o     = tmr_exc;
  assign busy_o          = seq_busy;
  assign sr_req_o        = seq_req;
  assign instr_done_o    = seq_done;
  assign cycle_type_o    = seq_type;
  assign cycles_o        = seq_cycles;

  cscc_phase_timer u_timer (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .ce_i        (ce_i),
    .start_i     (grant),
    .ready_o     (tmr_ready),
    .active_o    (tmr_active),
    .read_o      (tmr_read),
    .write_o     (tmr_write),
    .inhibit_o   (tmr_inhibit),
    .divert_o    (tmr_divert),
    .cycle_end_o (tmr_end),
    .pulse_o     (tmr_pulse),
    .excursion_o (tmr_exc)
  );

  cscc_seq_ctrl u_seq (
    .clock_i       (clock_i),
    .nrst_i        (nrst_i),
    .ce_i          (ce_i),
    .instr_start_i (instr_start_i),
    .kind_i        (seq_kind_i),
    .grant_i       (grant),
    .cycle_end_i   (tmr_end),
    .req_o         (seq_req),
    .busy_o        (seq_busy),
    .instr_done_o  (seq_done),
    .cycle_type_o  (seq_type),
    .cycles_o      (seq_cycles)
  );

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      run_meta   <= 1'b0;
      run_sync   <= 1'b0;
      step_meta  <= 1'b0;
      step_sync  <= 1'b0;
      step_prev  <= 1'b0;
      sense_meta <= WORD_RESET;
      sense_sync <= WORD_RESET;
      size_meta  <= 1'b0;
      size_sync  <= 1'b0;
    end else if (ce_i) begin
      run_meta   <= run_i;
      run_sync   <= run_meta;
      step_meta  <= step_i;
      step_sync  <= step_meta;
      step_prev  <= step_sync;
      sense_meta <= sense_i;
      sense_sync <= sense_meta;
      size_meta  <= size_4k_i;
      size_sync  <= size_meta;
    end
  end

  // A step press allows exactly one cycle; a new press wins over the use.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      step_pending <= 1'b0;
    end else if (ce_i) begin
      if (step_edge) step_pending <= 1'b1;
      else if (grant && !run_sync) step_pending <= 1'b0;
    end
  end

  // The address is taken at the boundary and held until the next one.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      storage_addr_o  <= ADDR_RESET;
      cycle_to_buffer <= 1'b0;
      cycle_new_data  <= 1'b0;
    end else if (ce_i && grant) begin
      storage_addr_o  <= masked_addr;
      cycle_to_buffer <= use_buffer_i;
      cycle_new_data  <= store_new_i;
    end
  end

  // Driver and diverter selects, one shared coordinate for all planes.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      vert_driver_o   <= '0;
      horz_driver_o   <= '0;
      vert_diverter_o <= '0;
      horz_diverter_o <= '0;
    end else if (ce_i && grant) begin
      vert_driver_o   <= vert_drv_sel;
      horz_driver_o   <= horz_drv_sel;
      vert_diverter_o <= vert_div_sel;
      horz_diverter_o <= horz_div_sel;
    end
  end

  // Data register: loaded at the boundary, filled by sense during read,
  // and held unchanged through the write so the same word is restored.
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      storage_data_o <= WORD_RESET;
      buffer_data_o  <= WORD_RESET;
    end else if (ce_i) begin
      if (grant) begin
        if (use_buffer_i) buffer_data_o <= start_word;
        else storage_data_o <= start_word;
      end else if (sense_open) begin
        if (cycle_to_buffer) buffer_data_o <= captured_word;
        else storage_data_o <= captured_word;
      end
    end
  end

endmodule : cscc_storage_ctrl

// file: verification/cscc_storage_ctrl_properties.sv
`timescale 1ns/1ps
module cscc_storage_ctrl_properties
  import cscc_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              nrst_i,
  input wire logic              ce_i,
  input wire logic              sr_active_o,
  input wire logic              cycle_end_o,
  input wire logic              instr_done_o,
  input wire logic [4:0]        pulse_o,
  input wire logic [1:0]        excursion_o,
  input wire logic              read_phase_o,
  input wire logic              write_phase_o,
  input wire logic              inhibit_phase_o,
  input wire logic              divert_phase_o,
  input wire logic [WORD_W-1:0] inhibit_o,
  input wire logic [ADDR_W-1:0] storage_addr_o,
  input wire logic [WORD_W-1:0] storage_data_o,
  input wire logic [WORD_W-1:0] buffer_data_o
);
  // Cycles since the current window opened; keeps counting while idle and saturates at 10'h3ff.
  logic [9:0]  t_q;
  logic        act_q;
  logic [9:0]  t;
  logic [31:0] t_pulse;
  assign t = (sr_active_o && !act_q) ? 10'h000 : t_q;
  assign t_pulse = (32'(t) * 32'h18) / 32'h190;
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      t_q   <= 10'h3ff;
      act_q <= 1'b0;
    end else if (ce_i) begin
      act_q <= sr_active_o;
      t_q   <= (t == 10'h3ff) ? t : t + 10'h001;
    end
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  a_cycle_len: assert property ($fell(sr_active_o) |-> t == 10'h190)
    else $error("storage window has the wrong length");
  a_end_pulse: assert property (cycle_end_o == (t == 10'h190))
    else $error("cycle end pulse at the wrong time");
  a_read_span: assert property (sr_active_o |-> read_phase_o == (t < 10'h053))
    else $error("read phase span wrong");
  a_write_span: assert property (write_phase_o == (t >= 10'h11b && t < 10'h1cf))
    else $error("write phase span wrong");
  a_inhibit_match: assert property (inhibit_phase_o == write_phase_o)
    else $error("inhibit phase differs from write phase");
  a_divert_span: assert property ((read_phase_o || write_phase_o) |-> divert_phase_o)
    else $error("divert phase dropped during read or write");
  a_inhibit_bits: assert property (inhibit_o == (inhibit_phase_o ? ~storage_data_o : 8'h00) || inhibit_o == (inhibit_phase_o ? ~buffer_data_o : 8'h00))
    else $error("inhibit lines do not follow the zero data bits");
  a_start_gap: assert property ($rose(sr_active_o) |-> t_q >= 10'h1cf)
    else $error("cycle started before the write phase ended");
  a_pulse_map: assert property (sr_active_o |-> pulse_o == t_pulse[4:0])
    else $error("timing pulse number wrong");
  a_excursion_code: assert property (sr_active_o |-> excursion_o == ((pulse_o < 5'h08) ? 2'h0 : (pulse_o < 5'h10) ? 2'h1 : 2'h3))
    else $error("excursion code wrong");
  a_done_after: assert property (instr_done_o |-> $past(cycle_end_o))
    else $error("instruction done without a cycle end before it");
  a_addr_hold: assert property (sr_active_o && act_q |-> $stable(storage_addr_o))
    else $error("storage address changed within a cycle");
  c_cycle: cover property ($rose(sr_active_o));
  c_done: cover property (instr_done_o);
  c_inhibit: cover property (inhibit_o != 8'h00);
endmodule : cscc_storage_ctrl_properties

bind cscc_storage_ctrl cscc_storage_ctrl_properties cscc_storage_ctrl_properties_i (
  .clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce_i), .sr_active_o(sr_active_o),
  .cycle_end_o(cycle_end_o), .instr_done_o(instr_done_o), .pulse_o(pulse_o),
  .excursion_o(excursion_o), .read_phase_o(read_phase_o),
  .write_phase_o(write_phase_o), .inhibit_phase_o(inhibit_phase_o),
  .divert_phase_o(divert_phase_o), .inhibit_o(inhibit_o),
  .storage_addr_o(storage_addr_o), .storage_data_o(storage_data_o),
  .buffer_data_o(buffer_data_o));

// file: verification/cscc_core_model.sv
`timescale 1ns/1ps
module cscc_core_model
  import cscc_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              read_drive_i,
  input  wire logic              write_drive_i,
  input  wire logic [WORD_W-1:0] inhibit_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic [WORD_W-1:0]      sense_o
);
  logic [WORD_W-1:0] mem [WORDS_4K];
  logic              rd_q;
  initial begin
    for (int i = 0; i < WORDS_4K; i++) begin
      mem[i] = WORD_W'(i) ^ 8'h3c;
    end
  end
  // Ones give a large sense pulse for the whole read drive; zeros give none.
  always @(posedge clock_i) begin
    rd_q <= read_drive_i;
    sense_o <= read_drive_i ? mem[addr_i] : 8'h00;
    if (rd_q && !read_drive_i) begin
      mem[addr_i] <= 8'h00;
    end
    if (write_drive_i) begin
      mem[addr_i] <= mem[addr_i] | ~inhibit_i;
    end
  end
endmodule : cscc_core_model

// file: verification/cscc_storage_ctrl_test.sv
`timescale 1ns/1ps
module cscc_storage_ctrl_test;
  import cscc_pkg::*;
  logic              clock = 1'b0, nrst = 1'b0, run = 1'b0, step = 1'b0;
  logic              start = 1'b0, size_4k = 1'b1, use_buf = 1'b0;
  logic              store_new = 1'b0;
  cscc_seq_kind_type kind = CSCC_SEQ_SINGLE;
  logic [ADDR_W-1:0] addr = 12'h000, saddr;
  logic [WORD_W-1:0] wdata = 8'h00, sense, inhibit, sdata, bdata;
  logic              busy, sr_active, cycle_end, done, rd_drv, wr_drv;
  cscc_cycle_type    ctype;
  logic [2:0]        cycles;
  logic [7:0]        vdrv, hdrv, vdiv, hdiv;
  logic [31:0]       seen;
  int                n_errors = 0, n_tests = 0, n_cyc = 0;
  logic [31:0] exp_types [7] = '{32'h0000_0001, 32'h0000_0801, 32'h0008_0401,
                                 32'h0804_0201, 32'h1008_0401, 32'h0010_0801,
                                 32'h0101_0101};
  int          exp_len [7] = '{1, 2, 3, 4, 4, 3, 4};

  always #5 clock = ~clock;

  cscc_storage_ctrl cscc_storage_ctrl_i (
    .clock_i(clock), .nrst_i(nrst), .ce_i(1'b1), .size_4k_i(size_4k),
    .run_i(run), .step_i(step), .instr_start_i(start), .seq_kind_i(kind),
    .addr_i(addr), .use_buffer_i(use_buf), .store_new_i(store_new),
    .write_data_i(wdata), .sense_i(sense), .busy_o(busy), .sr_req_o(),
    .sr_active_o(sr_active), .cycle_end_o(cycle_end), .instr_done_o(done),
    .cycle_type_o(ctype), .cycles_o(cycles), .pulse_o(), .excursion_o(),
    .read_phase_o(), .write_phase_o(), .inhibit_phase_o(),
    .divert_phase_o(), .read_drive_o(rd_drv), .write_drive_o(wr_drv),
    .inhibit_o(inhibit), .vert_driver_o(vdrv), .horz_driver_o(hdrv),
    .vert_diverter_o(vdiv), .horz_diverter_o(hdiv),
    .storage_addr_o(saddr), .storage_data_o(sdata), .buffer_data_o(bdata));

  cscc_core_model cscc_core_model_i (
    .clock_i(clock), .read_drive_i(rd_drv), .write_drive_i(wr_drv),
    .inhibit_i(inhibit), .addr_i(saddr), .sense_o(sense));

  function automatic logic [7:0] pat(input logic [11:0] a);
    return a[7:0] ^ 8'h3c;
  endfunction : pat

  task automatic check(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  // The start is held for a second edge, which finds busy high and is ignored.
  task automatic begin_instr(input cscc_seq_kind_type k, input logic [11:0] a,
                             input logic ub, sn, input logic [7:0] wd);
    @(posedge clock);
    kind <= k;
    addr <= a;
    use_buf <= ub;
    store_new <= sn;
    wdata <= wd;
    start <= 1'b1;
    repeat (2) @(posedge clock);
    start <= 1'b0;
    n_cyc = 0;
    seen = 32'h0000_0000;
  endtask : begin_instr

  task automatic wait_done();
    int   n;
    logic act_q;
    n = 0;
    act_q = 1'b0;
    @(negedge clock);
    while (done !== 1'b1) begin
      if (sr_active === 1'b1 && !act_q && n_cyc < 4) begin
        seen[8*n_cyc +: 8] = {3'h0, ctype};
      end
      if (cycle_end === 1'b1) begin
        n_cyc++;
      end
      act_q = sr_active;
      n++;
      if (n > 4000) begin
        check("instr_done", 1, 0);
        report_and_stop();
      end
      @(negedge clock);
    end
  endtask : wait_done

  task automatic t_read_restore();
    logic [11:0] a;
    a = 12'hb5e;
    begin_instr(CSCC_SEQ_SINGLE, a, 1'b0, 1'b0, 8'h00);
    wait_done();
    check("data", pat(a), sdata);
    check("restore", pat(a), cscc_core_model_i.mem[a]);
    check("cycles", 1, cycles);
    check("vdrv", 8'h01 << {a[11], a[9], a[8]}, vdrv);
    check("hdrv", 8'h01 << {a[10], a[7], a[6]}, hdrv);
    check("vdiv", 8'h01 << a[5:3], vdiv);
    check("hdiv", 8'h01 << a[2:0], hdiv);
    begin_instr(CSCC_SEQ_SINGLE, 12'h0a3, 1'b1, 1'b0, 8'h00);
    wait_done();
    check("buffer", pat(12'h0a3), bdata);
  endtask : t_read_restore

  task automatic t_store_new();
    begin_instr(CSCC_SEQ_SINGLE, 12'h4c1, 1'b0, 1'b1, 8'h5a);
    wait_done();
    check("stored", 8'h5a, cscc_core_model_i.mem[12'h4c1]);
    check("newdata", 8'h5a, sdata);
  endtask : t_store_new

  task automatic t_sequences();
    for (int k = 0; k < 7; k++) begin
      begin_instr(cscc_seq_kind_type'(k), 12'h123, 1'b0, 1'b0, 8'h00);
      wait_done();
      check("types", exp_types[k], seen);
      check("count", exp_len[k], n_cyc);
      check("cycles", exp_len[k], cycles);
    end
  endtask : t_sequences

  task automatic t_step();
    @(posedge clock);
    run <= 1'b0;
    repeat (4) @(posedge clock);
    begin_instr(CSCC_SEQ_DIRECT, 12'h321, 1'b0, 1'b0, 8'h00);
    repeat (60) @(negedge clock);
    check("idle", 0, sr_active);
    @(posedge clock);
    step <= 1'b1;
    repeat (4) @(posedge clock);
    step <= 1'b0;
    repeat (1000) @(negedge clock);
    check("stepped", 1, cycles);
    check("busy", 1, busy);
    @(posedge clock);
    run <= 1'b1;
    wait_done();
    check("finished", 3, cycles);
  endtask : t_step

  task automatic t_small();
    @(posedge clock);
    size_4k <= 1'b0;
    begin_instr(CSCC_SEQ_SINGLE, 12'hfff, 1'b0, 1'b0, 8'h00);
    wait_done();
    check("addr2k", 12'h7ff, saddr);
    check("data2k", pat(12'h7ff), sdata);
    @(posedge clock);
    size_4k <= 1'b1;
  endtask : t_small

  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    run <= 1'b1;
    repeat (4) @(posedge clock);
    t_read_restore();
    t_store_new();
    t_sequences();
    t_step();
    t_small();
    report_and_stop();
  end
endmodule : cscc_storage_ctrl_test
